/* design/reset_interrupt_vector_map.sv */
// reset and interrupt vector address generator with wishbone registers
// assumes the core asserts take_i for one cycle per accepted interrupt
`timescale 1ns/1ps
module reset_interrupt_vector_map #(
    parameter logic [11:0] BOOT_START = vector_map_pkg::BOOT_START_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic boot_reset_select_fuse_i,
    input wire logic [17:0] irq_req_i,
    input wire logic take_i,
    output logic [11:0] reset_addr_o,
    output logic [11:0] fetch_addr_o,
    output logic fetch_valid_o,
    output logic irq_block_o,
    output logic [4:0] irq_pending_src_o,
    output logic irq_pending_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o
);
    import vector_map_pkg::*;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic fuse_s1_r, fuse_s2_r;
    logic [17:0] req_s1_r, req_s2_r;
    always_ff @(posedge clk_i) begin
        fuse_s1_r <= boot_reset_select_fuse_i;
        fuse_s2_r <= fuse_s1_r;
        req_s1_r <= irq_req_i;
        req_s2_r <= req_s1_r;
    end

    // fuse caught once after reset release, held until next reset
    logic fuse_prog_r, fuse_cap_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fuse_cap_r <= 1'b0;
            fuse_prog_r <= 1'b0;
        end else if (!fuse_cap_r) begin
            fuse_cap_r <= 1'b1;
            fuse_prog_r <= ~fuse_s2_r;
        end
    end

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_en = bus_req & wb_we_i & wb_sel_i[0];
    wire rd_en = bus_req & ~wb_we_i;
    wire hit_ctrl = wb_adr_i == ADR_CTRL;
    wire hit_stat = wb_adr_i == ADR_STAT;
    wire hit_mask = wb_adr_i == ADR_MASK;
    wire hit_last = wb_adr_i == ADR_LAST;
    wire ctrl_wr = wr_en & hit_ctrl;
    wire wr_chg = wb_dat_i[BIT_CHG];
    wire wr_sel = wb_dat_i[BIT_SEL];

    // ---------------------------------------------------------------
    // timed change sequence
    // ---------------------------------------------------------------
    guard_state_t guard_r, guard_nxt;
    logic [3:0] win_r, win_nxt;
    logic sel_r, sel_nxt;
    logic moved_ev, timeout_ev;
    wire chg_set = ctrl_wr & wr_chg;
    wire sel_write = ctrl_wr & ~wr_chg & (guard_r == GUARD_OPEN);

    always_comb begin
        guard_nxt = guard_r;
        win_nxt = win_r;
        sel_nxt = sel_r;
        moved_ev = 1'b0;
        timeout_ev = 1'b0;
        case (guard_r)
            GUARD_IDLE: begin
                if (chg_set) begin
                    guard_nxt = GUARD_OPEN;
                    win_nxt = WIN_CNT - 4'h1;
                end
            end
            GUARD_OPEN: begin
                if (sel_write) begin
                    sel_nxt = wr_sel;
                    moved_ev = 1'b1;
                    guard_nxt = GUARD_POST;
                    win_nxt = POST_CNT - 4'h1;
                end else if (chg_set) begin
                    win_nxt = WIN_CNT - 4'h1;
                end else if (win_r == 4'h0) begin
                    guard_nxt = GUARD_IDLE;
                    timeout_ev = 1'b1;
                end else begin
                    win_nxt = win_r - 4'h1;
                end
            end
            GUARD_POST: begin
                if (win_r == 4'h0) begin
                    guard_nxt = GUARD_IDLE;
                end else begin
                    win_nxt = win_r - 4'h1;
                end
            end
            default: begin
                guard_nxt = GUARD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            guard_r <= GUARD_IDLE;
            win_r <= 4'h0;
            sel_r <= 1'b0;
        end else begin
            guard_r <= guard_nxt;
            win_r <= win_nxt;
            sel_r <= sel_nxt;
        end
    end
    wire chg_bit = guard_r == GUARD_OPEN;
    // blocking also covers the write cycle itself
    wire blocked = chg_bit | (guard_r == GUARD_POST) | chg_set;

    // ---------------------------------------------------------------
    // pending source pick, lowest slot first
    // ---------------------------------------------------------------
    logic [4:0] pick;
    logic any;
    always_comb begin
        pick = 5'h00;
        any = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req_s2_r[i]) begin
                pick = 5'(i);
                any = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // vector address forming
    // ---------------------------------------------------------------
    vector_fetch_if vf ();
    wire [11:0] vec_base = sel_r ? BOOT_START : RESET_ADDR;
    assign vf.take = take_i & irq_pending_o;
    assign vf.src = irq_pending_src_o;
    assign vf.base = vec_base;
    vector_addr_former u_former (
        .vf(vf)
    );
    // reset address independent of the select bit
    wire [11:0] rst_addr_w = fuse_prog_r ? BOOT_START : RESET_ADDR;

    // ---------------------------------------------------------------
    // status, mask and interrupt
    // ---------------------------------------------------------------
    logic [2:0] stat_r, mask_r;
    logic [11:0] last_r;
    wire [2:0] ev = {moved_ev, timeout_ev, vf.take};
    wire stat_rd = rd_en & hit_stat;
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux[BIT_SEL] = sel_r;
            rd_mux[BIT_CHG] = chg_bit;
            rd_mux[BIT_FUSE] = fuse_prog_r;
        end else if (hit_stat) begin
            rd_mux[2:0] = stat_r;
        end else if (hit_mask) begin
            rd_mux[2:0] = mask_r;
        end else if (hit_last) begin
            rd_mux[11:0] = last_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_r <= 3'h0;
            mask_r <= 3'h0;
            last_r <= 12'h000;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            irq_o <= 1'b0;
        end else begin
            // set wins over the read clear
            stat_r <= (stat_rd ? 3'h0 : stat_r) | ev;
            if (wr_en & hit_mask) begin
                mask_r <= wb_dat_i[2:0];
            end
            if (vf.take) begin
                last_r <= vf.addr;
            end
            wb_ack_o <= bus_req;
            wb_dat_o <= rd_en ? rd_mux : 32'h0000_0000;
            irq_o <= |(((stat_rd ? 3'h0 : stat_r) | ev) & mask_r);
        end
    end

    // ---------------------------------------------------------------
    // core facing outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_addr_o <= RESET_ADDR;
            fetch_addr_o <= RESET_ADDR;
            fetch_valid_o <= 1'b0;
            irq_block_o <= 1'b0;
            irq_pending_src_o <= 5'h00;
            irq_pending_o <= 1'b0;
        end else begin
            reset_addr_o <= rst_addr_w;
            // fetch only on a taken interrupt
            fetch_valid_o <= vf.take;
            if (vf.take) begin
                fetch_addr_o <= vf.addr;
            end
            irq_block_o <= blocked;
            irq_pending_src_o <= pick;
            irq_pending_o <= any & ~blocked;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_vec_slot: assert property (vf.take |=>
        fetch_valid_o && fetch_addr_o ==
        $past(vec_base) + 12'(FIRST_VEC) + {7'h00, $past(vf.src)})
        else $error("vector address wrong");
    chk_app_base: assert property ((vf.take && !sel_r) |=>
        fetch_addr_o == {7'h00, $past(vf.src)} + 12'h001)
        else $error("application vector wrong");
    chk_boot_base: assert property ((vf.take && sel_r) |=>
        fetch_addr_o == BOOT_START + {7'h00, $past(vf.src)} + 12'h001)
        else $error("boot vector wrong");
    chk_reset_addr: assert property (fuse_cap_r ##1 fuse_cap_r |->
        reset_addr_o == (fuse_prog_r ? BOOT_START : 12'h000))
        else $error("reset address wrong");
    chk_fuse_sense: assert property ($rose(fuse_cap_r) |->
        fuse_prog_r == !$past(fuse_s2_r))
        else $error("fuse sense wrong");
    chk_no_fetch: assert property (!vf.take |=> !fetch_valid_o)
        else $error("fetch without take");
    // a select write or a fresh enable ends or restarts the window early
    chk_chg_clear: assert property ((guard_r == GUARD_IDLE && chg_set)
        ##1 (!sel_write && !chg_set) [*4] |->
        (chg_bit && $past(chg_bit, 3)) ##1 !chg_bit)
        else $error("change enable not cleared after four");
    chk_sel_hold: assert property (!sel_write |=> $stable(sel_r))
        else $error("select changed outside window");
    chk_block_gate: assert property (blocked |=> !irq_pending_o)
        else $error("interrupt not blocked");
    chk_base_indep: assert property ($changed(sel_r) &&
        $stable(fuse_prog_r) |=> $stable(reset_addr_o))
        else $error("reset address follows select");
    chk_first_slot: assert property ((vf.take && vf.src == 5'h00 &&
        !sel_r) |=> fetch_addr_o == 12'h001)
        else $error("first vector not 0x001");
    chk_last_slot: assert property ((vf.take && vf.src == 5'h11 &&
        !sel_r) |=> fetch_addr_o == 12'h012)
        else $error("last vector not 0x012");

    cov_move: cover property (sel_write ##1 sel_r);
    cov_timeout: cover property (timeout_ev);
    cov_take_boot: cover property (vf.take && sel_r);
    cov_irq: cover property (irq_o);
endmodule

/* design/vector_addr_former.sv */
// combinational vector address former
// assumes the source index is below the number of sources
`timescale 1ns/1ps
module vector_addr_former (
    vector_fetch_if.former vf
);
    import vector_map_pkg::*;
    // ---------------------------------------------------------------
    // table slot of a source
    // ---------------------------------------------------------------
    function automatic logic [11:0] slot(input logic [4:0] s);
        slot = FIRST_VEC + {7'h00, s};
    endfunction
    wire [11:0] slot_w = slot(vf.src);
    assign vf.addr = vf.base + slot_w;
endmodule

/* design/vector_fetch_if.sv */
// carries a taken interrupt from the core side to the address former
// assumes both ends share clk_i
`timescale 1ns/1ps
interface vector_fetch_if;
    logic take;
    logic [4:0] src;
    logic [11:0] base;
    logic [11:0] addr;
    modport ctl (output take, output src, output base, input addr);
    modport former (input take, input src, input base, output addr);
endinterface

/* design/vector_map_pkg.sv */
// constants and types for the reset and interrupt vector map
// assumes one 40 MHz clock and a classic wishbone master outside
// Contract
// - reset starts execution at address zero while the fuse is unprogrammed
// - external requests and timer2 at 0x001-0x004
// - timer1 capture, compares, overflow at 0x005-0x008
// - timer0 overflow 0x009, serial transfer 0x00a
// - usart receive, buffer empty, transmit 0x00b-0x00d
// - converter to store-program ready at 0x00e-0x012
// - programmed fuse moves reset to boot address
// - select bit adds boot start to vectors
// - reset address and vector base chosen independently
// - fuse one is unprogrammed, zero is programmed
// - vector fetched only when interrupt is taken
// - select zero puts vectors at flash start
// - enable then select within four cycles
// - block interrupts during the change sequence
package vector_map_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_SRC = 18;
    localparam int SRC_W = 5;
    localparam logic [11:0] RESET_ADDR = 12'h000;
    localparam logic [11:0] FIRST_VEC = 12'h001;
    localparam logic [11:0] BOOT_START_DEF = 12'hc00;
    localparam int CHANGE_WIN = 4;
    localparam logic [3:0] WIN_CNT = 4'h4;
    localparam logic [3:0] POST_CNT = 4'h2;
    // register byte addresses
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_MASK = 8'h08;
    localparam logic [7:0] ADR_LAST = 8'h0c;
    // control field positions
    localparam int BIT_SEL = 1;
    localparam int BIT_CHG = 0;
    localparam int BIT_FUSE = 2;
    // status field positions
    localparam int EV_TAKEN = 0;
    localparam int EV_TIMEOUT = 1;
    localparam int EV_MOVED = 2;
    localparam int EV_W = 3;
    typedef enum logic [1:0] {
        GUARD_IDLE = 2'b00,
        GUARD_OPEN = 2'b01,
        GUARD_POST = 2'b11
    } guard_state_t;
endpackage

/* verification/core_model.sv */
// core side model: takes a pending interrupt, promptly or slowly
// assumes the vector map's pending flag and a shared clock
`timescale 1ns/1ps
module core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic slow_i,
    input wire logic irq_pending_i,
    output logic take_o
);
    initial take_o = 1'b0;
    // -------------------------------------
    // take loop
    // -------------------------------------
    // no second take until pending drops, as a real core would
    always begin
        @(posedge clk_i);
        if (!rst_i && en_i && irq_pending_i === 1'b1) begin
            if (slow_i) begin
                repeat (3) @(posedge clk_i);
            end
            take_o <= 1'b1;
            @(posedge clk_i);
            take_o <= 1'b0;
            while (irq_pending_i === 1'b1) @(posedge clk_i);
        end
    end
endmodule

/* verification/testbench.sv */
// self-checking bench for the vector map, random and corner cases
// assumes the design package and the core model are compiled first
`timescale 1ns/1ps
module testbench;
    import vector_map_pkg::*;
    localparam logic [11:0] BOOT = 12'h800;
    logic clk_i, rst_i, fuse, take, en, slow;
    logic [17:0] irq_req;
    logic cyc, stb, we;
    logic [3:0] sel, wsel;
    logic [7:0] adr;
    logic [31:0] dat, wb_dat_o, q, r, seed;
    logic [11:0] reset_addr_o, fetch_addr_o;
    logic [4:0] src;
    logic fetch_valid_o, irq_block_o, irq_pending_o, wb_ack_o, irq_o;
    int failures, checked;
    reset_interrupt_vector_map #(.BOOT_START(BOOT)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .boot_reset_select_fuse_i(fuse),
        .irq_req_i(irq_req), .take_i(take), .reset_addr_o(reset_addr_o),
        .fetch_addr_o(fetch_addr_o), .fetch_valid_o(fetch_valid_o),
        .irq_block_o(irq_block_o), .irq_pending_src_o(src),
        .irq_pending_o(irq_pending_o), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
    core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .en_i(en),
        .slow_i(slow), .irq_pending_i(irq_pending_o), .take_o(take));
    // -------------------------------------
    // helpers
    // -------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [11:0] exp_vec(input logic s, input int i);
        return (s ? BOOT : 12'h000) + FIRST_VEC + 12'(i);
    endfunction
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkb(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask
    // ack is awaited without assuming its latency
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= wsel;
        dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) failures++;
    endtask
    task automatic vec(input int i, input logic s);
        int n;
        @(posedge clk_i) irq_req <= 18'h1 << i;
        n = 0;
        do begin @(posedge clk_i); n++; end
        while (fetch_valid_o !== 1'b1 && n < 40);
        chk("fetch_addr", 32'(exp_vec(s, i)), 32'(fetch_addr_o));
        chk("pending_src", 32'(i), 32'(src));
        irq_req <= '0;
        @(posedge clk_i);
        chkb("fetch_valid", 1'b0, fetch_valid_o);
        repeat (3) @(posedge clk_i);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // -------------------------------------
    // clock, watchdog, tests
    // -------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        #(25 * 20000);
        failures++;
        finish_test();
    end
    initial begin
        rst_i = 1'b1;
        fuse = 1'b1;
        irq_req = '0;
        en = 1'b1;
        slow = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = '0;
        dat = '0;
        sel = 4'hf;
        wsel = 4'hf;
        failures = 0; checked = 0; seed = 32'ha6b710eb;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("reset_addr", 32'h0, 32'(reset_addr_o));
        for (int i = 0; i < NUM_SRC; i++) begin
            vec(i, 1'b0);
        end
        wb(1'b0, ADR_LAST, 32'h0);
        chk("last_vec", 32'h012, q);
        $display("test application vectors done");
        wb(1'b1, ADR_MASK, 32'h1);
        // clear old takes first so the next check sees a fresh event
        wb(1'b0, ADR_STAT, 32'h0);
        chkb("irq_o", 1'b0, irq_o);
        // a write without byte lane zero must be ignored
        wsel = 4'he;
        wb(1'b1, ADR_MASK, 32'h0);
        wsel = 4'hf;
        wb(1'b0, ADR_MASK, 32'h0);
        chk("mask", 32'h1, q);
        vec(3, 1'b0);
        chkb("irq_o", 1'b1, irq_o);
        wb(1'b0, ADR_STAT, 32'h0);
        chk("status", 32'h1, q & 32'h1);
        repeat (2) @(posedge clk_i);
        chkb("irq_o", 1'b0, irq_o);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test status and mask done");
        en <= 1'b0; irq_req <= 18'h1;
        repeat (6) @(posedge clk_i);
        wb(1'b1, ADR_CTRL, 32'h1);
        @(posedge clk_i);
        chkb("irq_block", 1'b1, irq_block_o);
        chkb("irq_pending", 1'b0, irq_pending_o);
        repeat (6) @(posedge clk_i);
        wb(1'b0, ADR_CTRL, 32'h0);
        chk("ctrl", 32'h0, q & 32'h3);
        wb(1'b0, ADR_STAT, 32'h0);
        chk("timeout", 32'h2, q & 32'h2);
        repeat (5) @(posedge clk_i);
        chkb("irq_pending", 1'b1, irq_pending_o);
        // core stays off until the request has drained, no stray take
        irq_req <= '0;
        repeat (5) @(posedge clk_i);
        en <= 1'b1;
        $display("test change timeout done");
        wb(1'b1, ADR_CTRL, 32'h1);
        wb(1'b1, ADR_CTRL, 32'h2);
        repeat (4) @(posedge clk_i);
        wb(1'b0, ADR_CTRL, 32'h0);
        chk("ctrl", 32'h2, q & 32'h3);
        chkb("irq_block", 1'b0, irq_block_o);
        for (int i = 0; i < NUM_SRC; i++) vec(i, 1'b1);
        chk("reset_addr", 32'h0, 32'(reset_addr_o));
        for (int k = 0; k < 20; k++) begin
            r = xs();
            slow <= r[8];
            vec(int'(r % 32'd18), 1'b1);
        end
        $display("test boot vectors done");
        fuse <= 1'b0; rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("reset_addr", 32'(BOOT), 32'(reset_addr_o));
        wb(1'b0, ADR_CTRL, 32'h0);
        chk("ctrl", 32'h4, q & 32'h6);
        vec(17, 1'b0);
        $display("test boot reset done");
        finish_test();
    end
endmodule
